/* hdl/spp_pkg.sv */
// Shared constants for the six-bit port with direction control.
package spp_pkg;
	// ********************************************************
	// Widths
	// ********************************************************
	localparam int PIN_W = 6;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int CODE_W = 4;

	// ********************************************************
	// Register indices and byte addresses
	// ********************************************************
	localparam logic [9:0] IDX_PORT_A_DATA = 10'h005;
	localparam logic [9:0] IDX_PORT_A_DIRECTION = 10'h085;
	localparam logic [9:0] IDX_ANALOG_PIN_CONFIG = 10'h09F;
	localparam logic [9:0] IDX_WRITE_MASK = 10'h0C0;
	localparam logic [ADDR_W-1:0] ADDR_PORT_A_DATA = {IDX_PORT_A_DATA, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_PORT_A_DIRECTION =
		{IDX_PORT_A_DIRECTION, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_ANALOG_PIN_CONFIG =
		{IDX_ANALOG_PIN_CONFIG, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_WRITE_MASK = {IDX_WRITE_MASK, 2'h0};

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int POS_JUSTIFY = 7;
	localparam int POS_CODE_LO = 0;
	localparam int POS_TIMER_PIN = 4;
	localparam int POS_SELECT_PIN = 5;
	localparam int POS_REF_PIN = 3;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [PIN_W-1:0] RST_DIRECTION = 6'h3F;
	localparam logic [PIN_W-1:0] RST_DATA = 6'h00;
	localparam logic [CODE_W-1:0] RST_CODE = 4'h0;
	localparam logic RST_JUSTIFY = 1'b0;
	localparam logic [PIN_W-1:0] RST_WRITE_MASK = 6'h3F;

	// ********************************************************
	// Analog pin masks, one bit per pin
	// ********************************************************
	localparam logic [PIN_W-1:0] MASK_ALL_ANALOG = 6'h2F;
	localparam logic [PIN_W-1:0] MASK_LOW_THREE = 6'h0B;
	localparam logic [PIN_W-1:0] MASK_REF_ONLY_LOW = 6'h0F;
	localparam logic [PIN_W-1:0] MASK_PIN0 = 6'h01;
	localparam logic [PIN_W-1:0] MASK_PIN0_PIN3 = 6'h09;
	localparam logic [PIN_W-1:0] MASK_NONE = 6'h00;

	// ********************************************************
	// Bus sequencing states
	// ********************************************************
	typedef enum logic [2:0] {
		SPP_IDLE = 3'b001,
		SPP_ANSWER = 3'b010,
		SPP_DONE = 3'b100
	} spp_bus_e;
endpackage

/* hdl/spp_pin_sync.sv */
// Two-stage synchroniser for the pin input levels.
`timescale 1ns/1ns
`default_nettype none
module spp_pin_sync #(
	parameter int WIDTH = 6
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ********************************************************
	// Stages
	// ********************************************************
	// The first stage is seen only by the second; nothing else may read it.
	logic [WIDTH-1:0] stage1_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_r <= '0;
			sync_out <= '0;
		end else begin
			stage1_r <= async_in;
			sync_out <= stage1_r;
		end
	end
endmodule
`default_nettype wire

/* hdl/spp_port.sv */
// Six-bit bidirectional port with direction and analog pin selection.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module spp_port #(
	parameter int PIN_W = spp_pkg::PIN_W
) (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spp_pkg::ADDR_W-1:0] paddr,
	input wire logic [spp_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	// APB answer
	output logic [spp_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port pins
	input wire logic [PIN_W-1:0] pin_in,
	output logic [PIN_W-1:0] pin_out,
	output logic [PIN_W-1:0] pin_oe,
	// Shared peripheral side
	input wire logic slave_select_enable,
	output logic timer_zero_clock_input,
	output logic slave_select_n,
	output logic [PIN_W-1:0] analog_select,
	output logic reference_select,
	output logic result_justify_select
);
	// ********************************************************
	// Decoding functions
	// ********************************************************
	function automatic logic [PIN_W-1:0] analog_mask(
		input logic [spp_pkg::CODE_W-1:0] code
	);
		logic [PIN_W-1:0] m;
		m = spp_pkg::MASK_ALL_ANALOG;
		case (code)
			4'h4, 4'h5: m = spp_pkg::MASK_LOW_THREE;
			4'h6, 4'h7: m = spp_pkg::MASK_NONE;
			4'hD: m = spp_pkg::MASK_REF_ONLY_LOW;
			4'hE: m = spp_pkg::MASK_PIN0;
			4'hF: m = spp_pkg::MASK_PIN0_PIN3;
			default: m = spp_pkg::MASK_ALL_ANALOG;
		endcase
		return m;
	endfunction

	function automatic logic uses_reference(
		input logic [spp_pkg::CODE_W-1:0] code
	);
		logic r;
		r = 1'b0;
		case (code)
			4'h1, 4'h3, 4'h5, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic is_mapped(
		input logic [spp_pkg::ADDR_W-1:0] a
	);
		return (a == spp_pkg::ADDR_PORT_A_DATA) ||
			(a == spp_pkg::ADDR_PORT_A_DIRECTION) ||
			(a == spp_pkg::ADDR_ANALOG_PIN_CONFIG) ||
			(a == spp_pkg::ADDR_WRITE_MASK);
	endfunction

	// ********************************************************
	// Storage
	// ********************************************************
	logic [PIN_W-1:0] latch_r;
	logic [PIN_W-1:0] direction_r;
	logic [spp_pkg::CODE_W-1:0] code_r;
	logic justify_r;
	logic [PIN_W-1:0] write_mask_r;
	logic [PIN_W-1:0] pins_sync;
	spp_pkg::spp_bus_e bus_r;
	spp_pkg::spp_bus_e bus_nxt;

	// ********************************************************
	// Pin sampling
	// ********************************************************
	spp_pin_sync #(
		.WIDTH(PIN_W)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_in),
		.sync_out(pins_sync)
	);

	// ********************************************************
	// Combinational views
	// ********************************************************
	logic [PIN_W-1:0] amask;
	logic [PIN_W-1:0] digital_view;
	logic [PIN_W-1:0] owned_input;
	logic [PIN_W-1:0] merged_latch;
	logic [spp_pkg::DATA_W-1:0] read_word;
	logic setup_phase;
	logic commit;
	logic wr_ok;

	// A pin given to the converter reads zero on the digital side.
	assign amask = analog_mask(code_r);
	assign digital_view = pins_sync & ~amask;

	// Slave select takes pin five as an input while enabled.
	always_comb begin
		owned_input = '0;
		owned_input[spp_pkg::POS_SELECT_PIN] = slave_select_enable;
	end

	// Bits outside the write mask keep what the pins showed, as a
	// read-modify-write on a real port would.
	assign merged_latch = (digital_view & ~write_mask_r) |
		(pwdata[PIN_W-1:0] & write_mask_r);

	assign setup_phase = psel && !penable;
	assign commit = psel && penable && pready;
	assign wr_ok = commit && pwrite && !pslverr && pstrb[0];

	// ********************************************************
	// Write strobes
	// ********************************************************
	// One strobe per register; only the edge that ends the access may
	// write, so a master that holds its request never writes twice.
	logic wr_data;
	logic wr_dir;
	logic wr_cfg;
	logic wr_mask;

	assign wr_data = wr_ok && (paddr == spp_pkg::ADDR_PORT_A_DATA);
	assign wr_dir = wr_ok && (paddr == spp_pkg::ADDR_PORT_A_DIRECTION);
	assign wr_cfg = wr_ok && (paddr == spp_pkg::ADDR_ANALOG_PIN_CONFIG);
	assign wr_mask = wr_ok && (paddr == spp_pkg::ADDR_WRITE_MASK);

	always_comb begin
		read_word = '0;
		case (paddr)
			spp_pkg::ADDR_PORT_A_DATA:
				read_word[PIN_W-1:0] = digital_view;
			spp_pkg::ADDR_PORT_A_DIRECTION:
				read_word[PIN_W-1:0] = direction_r;
			spp_pkg::ADDR_ANALOG_PIN_CONFIG: begin
				read_word[spp_pkg::POS_JUSTIFY] = justify_r;
				read_word[spp_pkg::POS_CODE_LO +: spp_pkg::CODE_W] = code_r;
			end
			spp_pkg::ADDR_WRITE_MASK:
				read_word[PIN_W-1:0] = write_mask_r;
			default:
				read_word = '0;
		endcase
	end

	// ********************************************************
	// Bus sequencing
	// ********************************************************
	// The answer is always one access cycle long; ready is raised from a
	// flip-flop after the setup cycle so the bus sees no wait states.
	// Ready follows the sequencer, so no setup is ever answered twice.
	always_comb begin
		bus_nxt = bus_r;
		case (bus_r)
			spp_pkg::SPP_IDLE:
				if (setup_phase) begin
					bus_nxt = spp_pkg::SPP_ANSWER;
				end
			spp_pkg::SPP_ANSWER:
				bus_nxt = spp_pkg::SPP_DONE;
			spp_pkg::SPP_DONE:
				if (setup_phase) begin
					bus_nxt = spp_pkg::SPP_ANSWER;
				end else begin
					bus_nxt = spp_pkg::SPP_IDLE;
				end
			default:
				bus_nxt = spp_pkg::SPP_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_r <= spp_pkg::SPP_IDLE;
		end else begin
			bus_r <= bus_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (bus_nxt == spp_pkg::SPP_ANSWER) begin
			pready <= 1'b1;
			pslverr <= !is_mapped(paddr);
			prdata <= pwrite ? '0 : read_word;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
	end

	// ********************************************************
	// Registers
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_r <= spp_pkg::RST_DATA;
		end else if (wr_data) begin
			latch_r <= merged_latch;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direction_r <= spp_pkg::RST_DIRECTION;
		end else if (wr_dir) begin
			direction_r <= pwdata[PIN_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_r <= spp_pkg::RST_CODE;
			justify_r <= spp_pkg::RST_JUSTIFY;
		end else if (wr_cfg) begin
			code_r <= pwdata[spp_pkg::POS_CODE_LO +: spp_pkg::CODE_W];
			justify_r <= pwdata[spp_pkg::POS_JUSTIFY];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_mask_r <= spp_pkg::RST_WRITE_MASK;
		end else if (wr_mask) begin
			write_mask_r <= pwdata[PIN_W-1:0];
		end
	end

	// ********************************************************
	// Pin drivers
	// ********************************************************
	// Analog selection does not touch the drivers; software must leave
	// those direction bits set or the driver fights the analog source.
	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_pin
			if (gi == spp_pkg::POS_TIMER_PIN) begin : g_od
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						pin_out[gi] <= 1'b0;
						pin_oe[gi] <= 1'b0;
					end else begin
						pin_out[gi] <= 1'b0;
						pin_oe[gi] <= !direction_r[gi] && !latch_r[gi];
					end
				end
			end else begin : g_cmos
				always_ff @(posedge pclk or negedge presetn) begin
					if (!presetn) begin
						pin_out[gi] <= 1'b0;
						pin_oe[gi] <= 1'b0;
					end else begin
						pin_out[gi] <= latch_r[gi];
						pin_oe[gi] <= !direction_r[gi] && !owned_input[gi];
					end
				end
			end
		end
	endgenerate

	// ********************************************************
	// Peripheral side
	// ********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_zero_clock_input <= 1'b0;
		end else begin
			timer_zero_clock_input <= pins_sync[spp_pkg::POS_TIMER_PIN];
		end
	end

	// Software must pick a code that leaves pin five digital when the
	// slave select is in use; otherwise the select reads as asserted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_select_n <= 1'b1;
		end else begin
			slave_select_n <= !slave_select_enable ||
				digital_view[spp_pkg::POS_SELECT_PIN];
		end
	end

	// The converter side only follows the stored code and justify bit; it never touches
	// the drivers, which follow the direction register, the latch and the slave select enable on pin five.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_select <= spp_pkg::MASK_ALL_ANALOG;
		end else begin
			analog_select <= amask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reference_select <= 1'b0;
		end else begin
			reference_select <= uses_reference(code_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_justify_select <= spp_pkg::RST_JUSTIFY;
		end else begin
			result_justify_select <= justify_r;
		end
	end
endmodule
`default_nettype wire

/* testbench/spp_port_sva.sv */
// Checker of the six-bit port's bus answers and pin outputs.
`timescale 1ns/1ns
`default_nettype none
module spp_port_sva #(
	parameter int PIN_W = spp_pkg::PIN_W
) (
	// Clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [spp_pkg::ADDR_W-1:0] paddr,
	input wire logic [spp_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and shared peripherals
	input wire logic [PIN_W-1:0] pin_in,
	input wire logic [PIN_W-1:0] pin_out,
	input wire logic [PIN_W-1:0] pin_oe,
	input wire logic slave_select_enable,
	input wire logic timer_zero_clock_input,
	input wire logic slave_select_n,
	input wire logic [PIN_W-1:0] analog_select
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup;
	logic mapped;
	assign setup = psel && !penable;
	assign mapped = paddr inside {spp_pkg::ADDR_PORT_A_DATA,
		spp_pkg::ADDR_PORT_A_DIRECTION, spp_pkg::ADDR_ANALOG_PIN_CONFIG,
		spp_pkg::ADDR_WRITE_MASK};
	chk_ready_next: assert property (setup |=> pready)
		else $error("no answer after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	chk_err_unmapped: assert property (setup && !mapped |=>
		pslverr && prdata == 32'h0) else $error("unmapped not refused");
	chk_ok_mapped: assert property (setup && mapped |=> !pslverr)
		else $error("mapped access refused");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_data_top: assert property (setup && paddr ==
		spp_pkg::ADDR_PORT_A_DATA |=> prdata[7:6] == 2'h0)
		else $error("data top bits set");
	chk_open_drain: assert property (pin_out[4] == 1'b0)
		else $error("pin four driven high");
	chk_ana_four: assert property (analog_select[4] == 1'b0)
		else $error("pin four marked analog");
	chk_ssel_idle: assert property (!slave_select_enable |=>
		slave_select_n) else $error("select active while off");
	chk_ssel_own: assert property (slave_select_enable |=> !pin_oe[5])
		else $error("pin five driven while shared");
	chk_timer_pin: assert property (($stable(pin_in[4]) [*4]) ##0
		$past(presetn, 4) |-> timer_zero_clock_input == pin_in[4])
		else $error("timer clock lag");
	cover property (setup && psel);
	cover property (pslverr);
	cover property (slave_select_enable && !slave_select_n);
endmodule
bind spp_port spp_port_sva #(.PIN_W(PIN_W)) i_sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe(pin_oe),
	.slave_select_enable(slave_select_enable),
	.timer_zero_clock_input(timer_zero_clock_input),
	.slave_select_n(slave_select_n), .analog_select(analog_select));
`default_nettype wire

/* testbench/spp_pad_model.sv */
// Model of the pads and of the outside circuit that drives them.
`timescale 1ns/1ns
`default_nettype none
module spp_pad_model (
	// From the port
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	// Outside drive and resulting level
	input wire logic [5:0] ext_drv,
	output logic [5:0] pin_in
);
	// The port wins where it drives; pin four can only pull low.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the six-bit port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [11:0] A_DAT = spp_pkg::ADDR_PORT_A_DATA;
	localparam logic [11:0] A_DIR = spp_pkg::ADDR_PORT_A_DIRECTION;
	localparam logic [11:0] A_CFG = spp_pkg::ADDR_ANALOG_PIN_CONFIG;
	localparam logic [11:0] A_MSK = spp_pkg::ADDR_WRITE_MASK;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic sse = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [5:0] ext = 6'h3F;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, tclk, ssn, rsel, jsel;
	logic [5:0] pin_in, pin_out, pin_oe, asel;
	int n_fail = 0;
	int n_compared = 0;
	spp_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.slave_select_enable(sse), .timer_zero_clock_input(tclk),
		.slave_select_n(ssn), .analog_select(asel),
		.reference_select(rsel), .result_justify_select(jsel));
	spp_pad_model i_pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext),
		.pin_in(pin_in));
	function automatic logic [5:0] amask(input logic [3:0] c);
		case (c)
			4'h4, 4'h5: amask = 6'h0B;
			4'h6, 4'h7: amask = 6'h00;
			4'hD: amask = 6'h0F;
			4'hE: amask = 6'h01;
			4'hF: amask = 6'h09;
			default: amask = 6'h2F;
		endcase
	endfunction
	function automatic logic [5:0] oe_x(input logic [5:0] d, l,
		input logic s);
		oe_x = ~d;
		oe_x[4] = ~d[4] & ~l[4];
		oe_x[5] = ~d[5] & ~s;
	endfunction
	function automatic logic [5:0] lvl(input logic [5:0] d, l, e,
		input logic s);
		lvl = (oe_x(d, l, s) & l) | (~oe_x(d, l, s) & e);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Holds the request until pready is sampled, then idles one cycle.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			n_fail++;
			end_sim();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	initial begin
		forever #50 pclk = ~pclk;
	end
	initial begin
		logic [5:0] d, l, e, m, wd;
		logic s, j;
		l = 6'h00;
		void'($urandom(84031));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk(asel, 6'h2F);
		chk(pin_oe, 6'h00);
		rdchk(A_DIR, 32'h3F);
		rdchk(A_CFG, 32'h0);
		rdchk(A_DAT, 32'h10);
		apb(1'b0, 12'h004, 32'h0);
		chk(er, 1'b1);
		// A refused write and a write with its low strobe off change nothing.
		apb(1'b1, 12'h008, 32'h0);
		chk(er, 1'b1);
		pstrb <= 4'h0;
		apb(1'b1, A_DIR, 32'h0);
		pstrb <= 4'hF;
		rdchk(A_DIR, 32'h3F);
		// Direction stays all-input while pins are analog.
		for (int c = 0; c < 16; c++) begin
			j = 1'($urandom);
			apb(1'b1, A_CFG, {24'h0, j, 3'h0, 4'(c)});
			repeat (4) @(posedge pclk);
			chk(asel, amask(4'(c)));
			chk(rsel, c inside {1, 3, 5, 8, 10, 11, 12, 13, 15});
			chk(jsel, j);
			rdchk(A_CFG, {24'h0, j, 3'h0, 4'(c)});
			rdchk(A_DAT, ext & ~amask(4'(c)));
		end
		apb(1'b1, A_CFG, 32'h6);
		repeat (24) begin
			e = 6'($urandom);
			s = 1'($urandom);
			d = 6'($urandom);
			m = 6'($urandom);
			wd = 6'($urandom);
			ext <= e;
			sse <= s;
			apb(1'b1, A_MSK, {26'h0, m});
			apb(1'b1, A_DIR, {26'h0, d});
			repeat (4) @(posedge pclk);
			l = (lvl(d, l, e, s) & ~m) | (wd & m);
			apb(1'b1, A_DAT, {26'h0, wd});
			repeat (4) @(posedge pclk);
			chk(pin_oe, oe_x(d, l, s));
			chk(pin_out, l & 6'h2F);
			rdchk(A_DAT, lvl(d, l, e, s));
			chk(ssn, s ? lvl(d, l, e, s) >> 5 : 1'b1);
			chk(tclk, lvl(d, l, e, s) >> 4 & 6'h01);
		end
		end_sim();
	end
endmodule
`default_nettype wire
